/* File: common/sgc_pkg.sv */
// Constants and types shared by the switch global control block
package sgc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets on the management register port
    localparam logic [7:0] GC1_ADDR = 8'h03;
    localparam logic [7:0] GC2_ADDR = 8'h04;

    // Field positions of global_control_one
    localparam int unsigned GC1_PASS_ALL = 7;
    localparam int unsigned GC1_FRAME_2K = 6;
    localparam int unsigned GC1_TX_PAUSE_DIS = 5;
    localparam int unsigned GC1_RX_PAUSE_DIS = 4;
    localparam int unsigned GC1_LEN_CHECK = 3;
    localparam int unsigned GC1_AGING_EN = 2;
    localparam int unsigned GC1_FAST_AGE = 1;
    localparam int unsigned GC1_AGGR_BACKOFF = 0;

    // Field positions of global_control_two
    localparam int unsigned GC2_VLAN_DISCARD = 7;
    localparam int unsigned GC2_MCAST_EXCL = 6;

    // Reset values; strap bits start at zero until the straps are loaded
    localparam logic [7:0] GC1_RESET = 8'h04;
    localparam logic [7:0] GC2_RESET = 8'hc0;
    // Only the two upper bits of the second byte are implemented
    localparam logic [7:0] GC2_MASK = 8'hc0;

    ////////////////////////////////////////////////////////////////////////////
    // Frame length limits, in bytes
    localparam logic [15:0] LEN_CHECK_LIMIT = 16'h05dc;
    localparam logic [15:0] MAX_LEN_STD = 16'h05ee;
    localparam logic [15:0] MAX_LEN_2K = 16'h0800;

    ////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam longint unsigned CLK_MHZ = 64'h64;
    localparam longint unsigned FAST_AGE_US = 64'h320;
    localparam longint unsigned NORMAL_AGE_S = 64'h12c;
    localparam longint unsigned FAST_AGE_CYCLES = FAST_AGE_US * CLK_MHZ;
    localparam longint unsigned NORMAL_AGE_CYCLES = NORMAL_AGE_S * 64'hf4240 * CLK_MHZ;
    localparam int unsigned AGE_CNT_W = 36;

    ////////////////////////////////////////////////////////////////////////////
    // Frame descriptor offered for a forwarding verdict
    typedef struct packed {
        logic err;
        logic [15:0] len_type;
        logic [15:0] data_len;
        logic [15:0] frame_len;
        logic da_bcast;
        logic da_mcast;
        logic known_ucast;
        logic vlan_cross;
    } sgc_frame_t;

    typedef struct packed {
        logic drop;
        logic storm_count;
    } sgc_verdict_t;

    // Global configuration as seen by the switch core
    typedef struct packed {
        logic pass_all;
        logic frame_2k;
        logic len_check;
        logic aging_en;
        logic fast_age;
        logic aggr_backoff;
        logic vlan_discard;
        logic mcast_excl;
    } sgc_cfg_t;

    typedef enum logic [3:0] {
        SGC_SYNC0 = 4'b0001,
        SGC_SYNC1 = 4'b0010,
        SGC_LOAD = 4'b0100,
        SGC_DONE = 4'b1000
    } sgc_strap_state_t;

endpackage

/* File: hdl/sgc_strap_sampler.sv */
// Strap pin synchroniser and one-shot loader after reset release
module sgc_strap_sampler (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic pause_strap_pin,
    input wire logic backoff_strap_pin,
    output logic load_q,
    output logic pause_q,
    output logic backoff_q
);

    logic [1:0] sync1_q;
    logic [1:0] sync2_q;
    logic load_d;
    logic pause_d;
    logic backoff_d;
    sgc_pkg::sgc_strap_state_t state_q;
    sgc_pkg::sgc_strap_state_t state_d;

    ////////////////////////////////////////////////////////////////////////////
    // Wait for the synchroniser to fill, then load once
    always_comb begin
        state_d = state_q;
        load_d = 1'b0;
        pause_d = pause_q;
        backoff_d = backoff_q;
        unique case (state_q)
            sgc_pkg::SGC_SYNC0: begin
                state_d = sgc_pkg::SGC_SYNC1;
            end
            sgc_pkg::SGC_SYNC1: begin
                state_d = sgc_pkg::SGC_LOAD;
            end
            sgc_pkg::SGC_LOAD: begin
                load_d = 1'b1; // R13
                pause_d = sync2_q[1]; // R5
                backoff_d = sync2_q[0]; // R10
                state_d = sgc_pkg::SGC_DONE;
            end
            sgc_pkg::SGC_DONE: begin
                state_d = sgc_pkg::SGC_DONE;
            end
            default: begin
                state_d = sgc_pkg::SGC_DONE;
            end
        endcase
    end

    // Reset can only hold constants, so the pins are read after release
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            state_q <= sgc_pkg::SGC_SYNC0;
            load_q <= 1'b0;
            pause_q <= 1'b0;
            backoff_q <= 1'b0;
        end else begin
            sync1_q <= {pause_strap_pin, backoff_strap_pin};
            sync2_q <= sync1_q;
            state_q <= state_d;
            load_q <= load_d;
            pause_q <= pause_d;
            backoff_q <= backoff_d;
        end
    end

endmodule // sgc_strap_sampler

/* File: hdl/sgc_global_control.sv */
// Global switch control registers and the decisions they steer
//
// Functional notes
// R1 - Pass-all forwards every frame, even bad, except port-VLAN crossings blocked by the fence (discard set or DA not known unicast)
// R2 - 2K frames accepted only when bit set
// R3 - Tx pause follows autoneg unless disabled
// R4 - Rx pause follows autoneg unless disabled
// R5 - One strap sets both pause-disable defaults
// R6 - Length check drops mismatches below 1500
// R7 - Address aging runs only when enabled
// R8 - Fast age uses 800us period
// R9 - Aggressive back-off for half duplex
// R10 - Back-off default follows its strap
// R11 - Port-VLAN discard blocks all boundary crossings
// R12 - Storm counting may exclude multicast frames
// R13 - Straps load into register after reset
module sgc_global_control #(
    parameter longint unsigned FAST_AGE_CYCLES = sgc_pkg::FAST_AGE_CYCLES,
    parameter longint unsigned NORMAL_AGE_CYCLES = sgc_pkg::NORMAL_AGE_CYCLES
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_q,
    input wire logic pause_strap_pin,
    input wire logic backoff_strap_pin,
    input wire logic an_tx_pause,
    input wire logic an_rx_pause,
    input wire logic frame_valid,
    input wire sgc_pkg::sgc_frame_t frame,
    output logic verdict_valid_q,
    output sgc_pkg::sgc_verdict_t verdict_q,
    output logic tx_flow_en_q,
    output logic rx_flow_en_q,
    output logic age_tick_q,
    output sgc_pkg::sgc_cfg_t cfg_q
);

    // Terminal counts; the aging counter runs from zero up to these
    localparam logic [sgc_pkg::AGE_CNT_W-1:0] FAST_LAST =
        sgc_pkg::AGE_CNT_W'(FAST_AGE_CYCLES - 64'h1);
    localparam logic [sgc_pkg::AGE_CNT_W-1:0] NORMAL_LAST =
        sgc_pkg::AGE_CNT_W'(NORMAL_AGE_CYCLES - 64'h1);

    // Strap loader outputs
    logic strap_load;
    logic strap_pause;
    logic strap_backoff;

    // Register bytes and read data
    logic [7:0] gc1_q;
    logic [7:0] gc1_d;
    logic [7:0] gc2_q;
    logic [7:0] gc2_d;
    logic [7:0] rdata_d;

    // Flow enables and frame verdict
    logic tx_flow_en_d;
    logic rx_flow_en_d;
    logic verdict_valid_d;
    sgc_pkg::sgc_verdict_t verdict_d;

    // Aging timer
    logic [sgc_pkg::AGE_CNT_W-1:0] age_cnt_q;
    logic [sgc_pkg::AGE_CNT_W-1:0] age_cnt_d;
    logic [sgc_pkg::AGE_CNT_W-1:0] age_last;
    logic age_fast_q;
    logic age_fast_d;
    logic age_tick_d;

    // Length field check result, used by the drop decision
    function automatic logic len_mismatch(input sgc_pkg::sgc_frame_t f);
        return (f.len_type < sgc_pkg::LEN_CHECK_LIMIT) && (f.len_type != f.data_len);
    endfunction

    // Size limit depends on the 2K enable
    function automatic logic too_long(input sgc_pkg::sgc_frame_t f, input logic en_2k);
        logic [15:0] limit;
        limit = en_2k ? sgc_pkg::MAX_LEN_2K : sgc_pkg::MAX_LEN_STD;
        return f.frame_len > limit;
    endfunction

    // Write decode, shared by both register bytes
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr, input logic [7:0] target);
        return wr && (addr == target);
    endfunction

    sgc_strap_sampler u_strap (
        .clock(clock),
        .reset_n(reset_n),
        .pause_strap_pin(pause_strap_pin),
        .backoff_strap_pin(backoff_strap_pin),
        .load_q(strap_load),
        .pause_q(strap_pause),
        .backoff_q(strap_backoff)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    always_comb begin
        gc1_d = gc1_q;
        gc2_d = gc2_q;
        rdata_d = reg_rdata_q;
        if (strap_load) begin
            // Straps only seed the defaults; later writes overwrite freely
            gc1_d[sgc_pkg::GC1_TX_PAUSE_DIS] = strap_pause; // R5
            gc1_d[sgc_pkg::GC1_RX_PAUSE_DIS] = strap_pause; // R5
            gc1_d[sgc_pkg::GC1_AGGR_BACKOFF] = strap_backoff; // R10
        end else if (wr_hit(reg_wr, reg_addr, sgc_pkg::GC1_ADDR)) begin
            gc1_d = reg_wdata;
        end else if (wr_hit(reg_wr, reg_addr, sgc_pkg::GC2_ADDR)) begin
            gc2_d = reg_wdata & sgc_pkg::GC2_MASK;
        end
        // Reads see the byte as it stood before a same-cycle write
        if (reg_rd) begin
            // Unmapped offsets read as zero
            unique case (reg_addr)
                sgc_pkg::GC1_ADDR: rdata_d = gc1_q;
                sgc_pkg::GC2_ADDR: rdata_d = gc2_q;
                default: rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gc1_q <= sgc_pkg::GC1_RESET;
            gc2_q <= sgc_pkg::GC2_RESET;
            reg_rdata_q <= 8'h00;
        end else begin
            gc1_q <= gc1_d;
            gc2_q <= gc2_d;
            reg_rdata_q <= rdata_d;
        end
    end

    // Configuration leaves straight from the register flops
    assign cfg_q.pass_all = gc1_q[sgc_pkg::GC1_PASS_ALL];
    assign cfg_q.frame_2k = gc1_q[sgc_pkg::GC1_FRAME_2K];
    assign cfg_q.len_check = gc1_q[sgc_pkg::GC1_LEN_CHECK];
    assign cfg_q.aging_en = gc1_q[sgc_pkg::GC1_AGING_EN];
    assign cfg_q.fast_age = gc1_q[sgc_pkg::GC1_FAST_AGE];
    assign cfg_q.aggr_backoff = gc1_q[sgc_pkg::GC1_AGGR_BACKOFF]; // R9
    assign cfg_q.vlan_discard = gc2_q[sgc_pkg::GC2_VLAN_DISCARD];
    assign cfg_q.mcast_excl = gc2_q[sgc_pkg::GC2_MCAST_EXCL];

    ////////////////////////////////////////////////////////////////////////////
    // Flow control enables and frame verdicts
    always_comb begin
        tx_flow_en_d = an_tx_pause && !gc1_q[sgc_pkg::GC1_TX_PAUSE_DIS]; // R3
        rx_flow_en_d = an_rx_pause && !gc1_q[sgc_pkg::GC1_RX_PAUSE_DIS]; // R4
        verdict_valid_d = frame_valid;
        verdict_d.drop = 1'b0;
        verdict_d.storm_count = 1'b0;
        if (frame_valid) begin
            // Port-VLAN fence holds even in pass-all, which lets bad, oversize and length-mismatched frames by
            if (frame.vlan_cross &&
                    (gc2_q[sgc_pkg::GC2_VLAN_DISCARD] || !frame.known_ucast)) begin
                verdict_d.drop = 1'b1; // R11
            end else if (!gc1_q[sgc_pkg::GC1_PASS_ALL]) begin // R1
                if (frame.err) begin
                    verdict_d.drop = 1'b1;
                end
                if (too_long(frame, gc1_q[sgc_pkg::GC1_FRAME_2K])) begin
                    verdict_d.drop = 1'b1; // R2
                end
                if (gc1_q[sgc_pkg::GC1_LEN_CHECK] && len_mismatch(frame)) begin
                    verdict_d.drop = 1'b1; // R6
                end
            end
            // Storm counting sees every offered frame, dropped or not
            verdict_d.storm_count = frame.da_bcast ||
                (frame.da_mcast && !gc2_q[sgc_pkg::GC2_MCAST_EXCL]); // R12
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tx_flow_en_q <= 1'b0;
            rx_flow_en_q <= 1'b0;
            verdict_valid_q <= 1'b0;
            verdict_q <= '0;
        end else begin
            tx_flow_en_q <= tx_flow_en_d;
            rx_flow_en_q <= rx_flow_en_d;
            verdict_valid_q <= verdict_valid_d;
            verdict_q <= verdict_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Aging period timer
    always_comb begin
        age_fast_d = gc1_q[sgc_pkg::GC1_FAST_AGE];
        age_last = age_fast_q ? FAST_LAST : NORMAL_LAST; // R8
        age_tick_d = 1'b0;
        age_cnt_d = age_cnt_q + 1'b1;
        if (!gc1_q[sgc_pkg::GC1_AGING_EN]) begin
            // Parked at zero, so re-enabling always starts a full period
            age_cnt_d = '0; // R7
        end else if (age_fast_d != age_fast_q) begin
            // Restart on a period change so no stretched or cut period leaks out
            age_cnt_d = '0;
        end else if (age_cnt_q == age_last) begin // R8
            age_cnt_d = '0;
            age_tick_d = 1'b1; // R7
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            age_cnt_q <= '0;
            age_fast_q <= 1'b0;
            age_tick_q <= 1'b0;
        end else begin
            age_cnt_q <= age_cnt_d;
            age_fast_q <= age_fast_d;
            age_tick_q <= age_tick_d;
        end
    end

endmodule // sgc_global_control

/* File: tb/sgc_global_control_asserts.sv */
// Port checker for the switch global control block
module sgc_global_control_asserts #(
    parameter longint unsigned FAST_AGE_CYCLES = 20
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic backoff_strap_pin,
    input wire logic an_tx_pause,
    input wire logic an_rx_pause,
    input wire logic frame_valid,
    input wire sgc_pkg::sgc_frame_t frame,
    input wire logic verdict_valid_q,
    input wire sgc_pkg::sgc_verdict_t verdict_q,
    input wire logic tx_flow_en_q,
    input wire logic rx_flow_en_q,
    input wire logic age_tick_q,
    input wire sgc_pkg::sgc_cfg_t cfg_q
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] gap_q;
    logic [31:0] gap_d;
    logic run_q;
    logic [2:0] rel_q;
    logic [2:0] rel_d;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    ////////////////////////////////////////////////////////////////////////////
    // Gap holds at zero for the restart cycle the timer spends when fast aging starts
    always_comb begin
        gap_d = (age_tick_q || !run_q || !(cfg_q.fast_age && cfg_q.aging_en)) ? 32'h0 :
            gap_q + 32'h1;
        rel_d = (rel_q == 3'h7) ? rel_q : rel_q + 3'h1;
    end
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            gap_q <= 32'h0;
            run_q <= 1'b0;
            rel_q <= 3'h0;
        end else begin
            gap_q <= gap_d;
            run_q <= cfg_q.fast_age && cfg_q.aging_en;
            rel_q <= rel_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_verdict_next: assert property (frame_valid |=> verdict_valid_q)
        else $error("verdict missing after frame");
    a_verdict_idle: assert property (!frame_valid |=> !verdict_valid_q && verdict_q == '0)
        else $error("verdict without frame");
    a_pause_tx: assert property (tx_flow_en_q |-> $past(an_tx_pause))
        else $error("tx flow without autoneg");
    a_pause_rx: assert property (rx_flow_en_q |-> $past(an_rx_pause))
        else $error("rx flow without autoneg");
    a_bad_dropped: assert property (frame_valid && frame.err && !cfg_q.pass_all
        |=> verdict_q.drop) else $error("bad frame forwarded");
    a_pass_all_fwd: assert property (frame_valid && cfg_q.pass_all && !frame.vlan_cross
        |=> !verdict_q.drop) else $error("pass all frame dropped");
    a_size_limit: assert property (frame_valid && !cfg_q.pass_all
        && frame.frame_len > (cfg_q.frame_2k ? sgc_pkg::MAX_LEN_2K : sgc_pkg::MAX_LEN_STD)
        |=> verdict_q.drop) else $error("oversize frame forwarded");
    a_len_mismatch: assert property (frame_valid && cfg_q.len_check && !cfg_q.pass_all
        && frame.len_type < sgc_pkg::LEN_CHECK_LIMIT && frame.len_type != frame.data_len
        |=> verdict_q.drop)
        else $error("length mismatch forwarded");
    a_vlan_block: assert property (frame_valid && frame.vlan_cross && cfg_q.vlan_discard
        |=> verdict_q.drop) else $error("vlan crossing forwarded");
    a_storm_count: assert property (frame_valid |=> verdict_q.storm_count
        == $past(frame.da_bcast || (frame.da_mcast && !cfg_q.mcast_excl)))
        else $error("storm count wrong");
    a_age_idle: assert property (!cfg_q.aging_en [*2] |-> !age_tick_q)
        else $error("tick while aging off");
    a_fast_period: assert property (cfg_q.fast_age && cfg_q.aging_en |->
        gap_q <= FAST_AGE_CYCLES && (!age_tick_q || gap_q + 32'h1 >= FAST_AGE_CYCLES))
        else $error("fast age period wrong");
    a_strap_load: assert property (rel_q == 3'h4
        |-> cfg_q.aggr_backoff == backoff_strap_pin) else $error("backoff strap not loaded");
    c_pass_bad: cover property (frame_valid && frame.err && cfg_q.pass_all);
    c_fast_tick: cover property (age_tick_q && cfg_q.fast_age);
    c_vlan_open: cover property (frame_valid && frame.vlan_cross && !cfg_q.vlan_discard);
endmodule // sgc_global_control_asserts

bind sgc_global_control sgc_global_control_asserts #(
    .FAST_AGE_CYCLES(FAST_AGE_CYCLES)
) chk_u (.clock, .reset_n, .backoff_strap_pin, .an_tx_pause, .an_rx_pause, .frame_valid,
    .frame, .verdict_valid_q, .verdict_q, .tx_flow_en_q, .rx_flow_en_q, .age_tick_q, .cfg_q);

/* File: tb/sgc_global_control_tb.sv */
// Self-checking bench for the switch global control block
module sgc_global_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] reg_addr = 8'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h0;
    logic pause_strap_pin = 1'b0;
    logic backoff_strap_pin = 1'b0;
    logic an_tx_pause = 1'b0;
    logic an_rx_pause = 1'b0;
    logic frame_valid = 1'b0;
    sgc_pkg::sgc_frame_t frame = '0;
    logic [7:0] reg_rdata_q;
    logic verdict_valid_q;
    sgc_pkg::sgc_verdict_t verdict_q;
    logic tx_flow_en_q;
    logic rx_flow_en_q;
    logic age_tick_q;
    sgc_pkg::sgc_cfg_t cfg_q;
    int fail_count = 0;
    int checked = 0;

    always #5 clock = ~clock;

    // Short aging periods keep the run brief
    sgc_global_control #(.FAST_AGE_CYCLES(20), .NORMAL_AGE_CYCLES(50)) dut_u (
        .clock, .reset_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata_q,
        .pause_strap_pin, .backoff_strap_pin, .an_tx_pause, .an_rx_pause, .frame_valid,
        .frame, .verdict_valid_q, .verdict_q, .tx_flow_en_q, .rx_flow_en_q, .age_tick_q,
        .cfg_q);

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // Straps stay put after release, as the loader samples them late
    task automatic rst(input logic p, input logic b);
        @(negedge clock);
        reset_n = 1'b0;
        pause_strap_pin = p;
        backoff_strap_pin = b;
        repeat (5) @(negedge clock);
        reset_n = 1'b1;
        repeat (6) @(negedge clock);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        cmp(reg_rdata_q, e);
    endtask
    task automatic flow(input logic [7:0] c, input logic [1:0] e);
        wr(8'h03, c);
        repeat (2) @(negedge clock);
        cmp({tx_flow_en_q, rx_flow_en_q}, e);
    endtask
    task automatic fv(input logic [7:0] c1, input logic [7:0] c2, input logic er,
            input logic [15:0] lt, input logic [15:0] fl, input logic [3:0] bmkv,
            input logic [1:0] e);
        wr(8'h03, c1);
        wr(8'h04, c2);
        @(negedge clock);
        frame = {er, lt, 16'h0041, fl, bmkv};
        frame_valid = 1'b1;
        @(negedge clock);
        frame_valid = 1'b0;
        cmp({verdict_valid_q, verdict_q}, {1'b1, e});
    endtask
    // Waits for one tick, then counts to the next; 200 means none came
    task automatic gap(input logic [7:0] c, input logic [15:0] e);
        int n;
        wr(8'h03, c);
        n = 0;
        while (age_tick_q !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (age_tick_q !== 1'b1 && n < 200);
        cmp(16'(n), e);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_straps();
        rst(1'b1, 1'b0);
        rd(8'h03, 8'h34);
        rd(8'h04, 8'hc0);
        rst(1'b0, 1'b1);
        rd(8'h03, 8'h05);
        cmp(cfg_q, 8'h17);
        $display("strap test done");
    endtask
    task automatic t_regs();
        wr(8'h03, 8'hff);
        rd(8'h03, 8'hff);
        wr(8'h04, 8'hff);
        rd(8'h04, 8'hc0);
        wr(8'h05, 8'h5a);
        rd(8'h05, 8'h00);
        wr(8'h03, 8'h01);
        cmp(cfg_q, 8'h07);
        $display("register test done");
    endtask
    task automatic t_flow();
        an_tx_pause = 1'b1;
        an_rx_pause = 1'b1;
        flow(8'h20, 2'b01);
        flow(8'h10, 2'b10);
        flow(8'h00, 2'b11);
        an_tx_pause = 1'b0;
        flow(8'h00, 2'b01);
        an_rx_pause = 1'b0;
        flow(8'h00, 2'b00);
        $display("flow test done");
    endtask
    task automatic t_frames();
        fv(8'h00, 8'h00, 1'b1, 16'h0800, 16'h0041, 4'h0, 2'b10);
        fv(8'h80, 8'h00, 1'b1, 16'h0800, 16'h0041, 4'h0, 2'b00);
        fv(8'h00, 8'h00, 1'b0, 16'h0800, 16'h05ef, 4'h0, 2'b10);
        fv(8'h00, 8'h00, 1'b0, 16'h0800, 16'h05ee, 4'h0, 2'b00);
        fv(8'h40, 8'h00, 1'b0, 16'h0800, 16'h0800, 4'h0, 2'b00);
        fv(8'h40, 8'h00, 1'b0, 16'h0800, 16'h0801, 4'h0, 2'b10);
        fv(8'h08, 8'h00, 1'b0, 16'h0040, 16'h0041, 4'h0, 2'b10);
        fv(8'h08, 8'h00, 1'b0, 16'h0041, 16'h0041, 4'h0, 2'b00);
        fv(8'h08, 8'h00, 1'b0, 16'h05dc, 16'h0041, 4'h0, 2'b00);
        fv(8'h00, 8'h00, 1'b0, 16'h0040, 16'h0041, 4'h0, 2'b00);
        fv(8'h88, 8'h00, 1'b0, 16'h0040, 16'h0041, 4'h0, 2'b00);
        fv(8'h00, 8'h80, 1'b0, 16'h0800, 16'h0041, 4'h3, 2'b10);
        fv(8'h00, 8'h00, 1'b0, 16'h0800, 16'h0041, 4'h3, 2'b00);
        fv(8'h00, 8'h00, 1'b0, 16'h0800, 16'h0041, 4'h1, 2'b10);
        fv(8'h00, 8'h40, 1'b0, 16'h0800, 16'h0041, 4'h4, 2'b00);
        fv(8'h00, 8'h00, 1'b0, 16'h0800, 16'h0041, 4'h4, 2'b01);
        fv(8'h00, 8'h40, 1'b0, 16'h0800, 16'h0041, 4'h8, 2'b01);
        $display("frame test done");
    endtask
    task automatic t_aging();
        gap(8'h06, 16'h0014);
        gap(8'h04, 16'h0032);
        gap(8'h00, 16'h00c8);
        $display("aging test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        t_straps();
        t_regs();
        t_flow();
        t_frames();
        t_aging();
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clock);
        $display("watchdog expired");
        fail_count++;
        print_verdict();
    end
endmodule // sgc_global_control_tb
